// ===== verilog/amp_mode_regs.vh
// Constants for the amplifier mode, gain and level control block.
// Assumes a 25 MHz core clock; all gains are held in 0.5 dB units.
`ifndef AMP_MODE_REGS_VH
`define AMP_MODE_REGS_VH

// Core clock rate
`define CLK_FREQ_MHZ        25
`define CLK_FREQ_KHZ        25000

// Operating mode codes
`define MODE_SERIAL         2'h0
`define MODE_GAIN_SEL       2'h1
`define MODE_LEVEL_CTRL     2'h2

// Fixed gains in gain-select mode, 0.5 dB units
`define GAIN_SEL_00         7'h0C
`define GAIN_SEL_01         7'h18
`define GAIN_SEL_10         7'h24
`define GAIN_SEL_11         7'h30

// Level control preset and floor, 0.5 dB units
`define LEVEL_PRESET_GAIN   7'h24
`define LEVEL_MIN_GAIN      7'h02

// Serial mode gain: 46 steps of 0.5 dB upward from 1 dB
`define SERIAL_GAIN_BASE    7'h02
`define SERIAL_GAIN_TOP     6'h2E
`define SERIAL_MUTE_CODE    6'h3F

// Level controller timing in printed units
`define ATTACK_STEP_US      256
`define HOLD_MIN_MS         90
`define HOLD_MAX_MS         120
`define RELEASE_STEP_MS     128

// Cycle counts; attack and release are per 0.5 dB step
`define ATTACK_STEP_CYC     (`ATTACK_STEP_US * `CLK_FREQ_MHZ)
`define HOLD_CYC            (`HOLD_MIN_MS * `CLK_FREQ_KHZ)
`define RELEASE_STEP_CYC    (`RELEASE_STEP_MS * `CLK_FREQ_KHZ)

// Level controller states
`define LVL_IDLE            2'h0
`define LVL_ATTACK          2'h1
`define LVL_HOLD            2'h2
`define LVL_RELEASE         2'h3

// Settling edges before the mode is first latched
`define MODE_SETTLE_CYC     3'h4

`endif

// ===== verilog/three_level_modulator.v
// One channel of three-level pulse density output modulation.
// Assumes a signed sample already scaled by the gain stage upstream.
`timescale 1ns/1ps

module three_level_modulator #(
  parameter SAMPLE_W = 16
) (
  input  wire                core_clk,
  input  wire                sys_rst,
  input  wire                enable,
  input  wire [SAMPLE_W-1:0] sample,
  output reg                 out_pos_leg,
  output reg                 out_neg_leg
);

  reg  [SAMPLE_W-1:0] acc;
  wire                negative;
  wire [SAMPLE_W-1:0] magnitude;
  wire [SAMPLE_W:0]   next_acc;

  // Magnitude drives pulse density; sign picks which leg leads
  assign negative  = sample[SAMPLE_W-1];
  assign magnitude = negative ? (~sample + {{(SAMPLE_W-1){1'b0}}, 1'b1}) : sample;
  assign next_acc  = {1'b0, acc} + {1'b0, magnitude};

  ////////////////////////////////////////////////////////////////////////////
  // Accumulate; carry out marks a differential pulse. Larger input means
  // more frequent carries, so density rises monotonically with level.
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc         <= {SAMPLE_W{1'b0}};
      out_pos_leg <= 1'b0;
      out_neg_leg <= 1'b0;
    end
    else if (!enable)
    begin
      acc         <= {SAMPLE_W{1'b0}};
      out_pos_leg <= 1'b0;
      out_neg_leg <= 1'b0;
    end
    else
    begin
      acc <= next_acc[SAMPLE_W-1:0];
      if (next_acc[SAMPLE_W])
      begin
        out_pos_leg <= ~negative;
        out_neg_leg <= negative;
      end
      else
      begin
        // Both legs equal: zero differential, little load current
        out_pos_leg <= 1'b0;
        out_neg_leg <= 1'b0;
      end
    end
  end

endmodule // three_level_modulator

// ===== verilog/amp_mode_gain_control.v
// Mode decode, gain selection, level controller and output stage control
// of a stereo switching amplifier. Assumes the analog front end senses the
// mode pin as two levels, a serial engine outside handles the two-wire bus,
// and an analog comparator reports output over threshold.
`timescale 1ns/1ps
`include "amp_mode_regs.vh"

module amp_mode_gain_control #(
  parameter        SAMPLE_W     = 16,
  parameter [21:0] ATTACK_CYC   = `ATTACK_STEP_CYC,
  parameter [21:0] HOLD_CYC     = `HOLD_CYC,
  parameter [21:0] RELEASE_CYC  = `RELEASE_STEP_CYC
) (
  input  wire                core_clk,
  input  wire                sys_rst,
  input  wire                shutdown_n,
  input  wire                mode_pin_low,
  input  wire                mode_pin_high,
  input  wire                ball_c3_in,
  input  wire                ball_c4_in,
  output reg                 ball_c4_out,
  output reg                 ball_c4_oe,
  input  wire                over_threshold,
  input  wire                serial_sda_drive_low,
  input  wire [5:0]          serial_gain_code,
  input  wire                serial_emission_limit,
  input  wire                serial_left_shutdown,
  input  wire                serial_right_shutdown,
  input  wire [SAMPLE_W-1:0] audio_left,
  input  wire [SAMPLE_W-1:0] audio_right,
  output reg  [1:0]          op_mode,
  output reg                 serial_if_enable,
  output reg                 bus_clk_in,
  output reg                 bus_data_in,
  output reg  [6:0]          gain_half_db,
  output reg                 mute,
  output reg                 auto_level_control,
  output reg                 emission_limit_on,
  output reg                 limiter_threshold_in,
  output reg  [1:0]          alc_state,
  output wire                out_pos_leg_left,
  output wire                out_neg_leg_left,
  output wire                out_pos_leg_right,
  output wire                out_neg_leg_right
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when stages 2 and 3
  // agree. Bit order: over, c4, c3, mode high, mode low, shutdown.
  localparam NSYNC = 6;

  reg  [NSYNC-1:0] sync1;
  reg  [NSYNC-1:0] sync2;
  reg  [NSYNC-1:0] sync3;
  reg  [NSYNC-1:0] pin_level;
  wire [NSYNC-1:0] agree;
  wire [NSYNC-1:0] raw_pins;

  assign raw_pins = {over_threshold, ball_c4_in, ball_c3_in,
                     mode_pin_high, mode_pin_low, shutdown_n};
  assign agree    = ~(sync2 ^ sync3);

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1     <= {NSYNC{1'b0}};
      sync2     <= {NSYNC{1'b0}};
      sync3     <= {NSYNC{1'b0}};
      pin_level <= {NSYNC{1'b0}};
    end
    else
    begin
      sync1     <= raw_pins;
      sync2     <= sync1;
      sync3     <= sync2;
      pin_level <= (sync3 & agree) | (pin_level & ~agree);
    end
  end

  wire dev_enabled = pin_level[0];
  wire mode_low_s  = pin_level[1];
  wire mode_high_s = pin_level[2];
  wire c3_s        = pin_level[3];
  wire c4_s        = pin_level[4];
  wire over_s      = pin_level[5];

  ////////////////////////////////////////////////////////////////////////////
  // Mode latch. Taken once the synchronisers have settled after reset, and
  // afterwards only while shut down, so a glitching strap cannot swap the
  // ball functions under a running amplifier.
  reg  [2:0] settle_cnt;
  reg        mode_valid;
  reg  [1:0] mode;
  reg  [1:0] next_mode;

  // High strap wins if both senses read active; that case is not legal
  always @*
  begin
    if (mode_high_s)
      next_mode = `MODE_GAIN_SEL;
    else if (mode_low_s)
      next_mode = `MODE_SERIAL;
    else
      next_mode = `MODE_LEVEL_CTRL;
  end

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      settle_cnt <= 3'h0;
      mode_valid <= 1'b0;
      mode       <= `MODE_LEVEL_CTRL;
    end
    else if (settle_cnt != `MODE_SETTLE_CYC)
      settle_cnt <= settle_cnt + 3'h1;
    else if (!mode_valid || !dev_enabled)
    begin
      mode_valid <= 1'b1;
      mode       <= next_mode;
    end
  end

  wire in_serial = mode_valid && (mode == `MODE_SERIAL);
  wire in_gain   = mode_valid && (mode == `MODE_GAIN_SEL);
  wire in_level  = mode_valid && (mode == `MODE_LEVEL_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Level controller: attack steps down, hold, release steps back up.
  // Timing is fixed; only threshold and emission enable reach the user.
  reg  [1:0]  lvl_state;
  reg  [21:0] lvl_cnt;
  reg  [6:0]  lvl_gain;

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lvl_state <= `LVL_IDLE;
      lvl_cnt   <= 22'h000000;
      lvl_gain  <= `LEVEL_PRESET_GAIN;
    end
    else if (!in_level || !dev_enabled)
    begin
      lvl_state <= `LVL_IDLE;
      lvl_cnt   <= 22'h000000;
      lvl_gain  <= `LEVEL_PRESET_GAIN;
    end
    else
    begin
      case (lvl_state)
        `LVL_IDLE:
        begin
          lvl_cnt <= 22'h000000;
          if (over_s)
            lvl_state <= `LVL_ATTACK;
        end
        `LVL_ATTACK:
        begin
          if (!over_s)
          begin
            lvl_state <= `LVL_HOLD;
            lvl_cnt   <= 22'h000000;
          end
          else if (lvl_cnt >= ATTACK_CYC - 22'h000001)
          begin
            lvl_cnt <= 22'h000000;
            if (lvl_gain > `LEVEL_MIN_GAIN)
              lvl_gain <= lvl_gain - 7'h01;
          end
          else
            lvl_cnt <= lvl_cnt + 22'h000001;
        end
        `LVL_HOLD:
        begin
          if (over_s)
          begin
            lvl_state <= `LVL_ATTACK;
            lvl_cnt   <= 22'h000000;
          end
          else if (lvl_cnt >= HOLD_CYC - 22'h000001)
          begin
            lvl_state <= `LVL_RELEASE;
            lvl_cnt   <= 22'h000000;
          end
          else
            lvl_cnt <= lvl_cnt + 22'h000001;
        end
        `LVL_RELEASE:
        begin
          if (over_s)
          begin
            lvl_state <= `LVL_ATTACK;
            lvl_cnt   <= 22'h000000;
          end
          else if (lvl_gain >= `LEVEL_PRESET_GAIN)
            lvl_state <= `LVL_IDLE;
          else if (lvl_cnt >= RELEASE_CYC - 22'h000001)
          begin
            lvl_cnt  <= 22'h000000;
            lvl_gain <= lvl_gain + 7'h01;
          end
          else
            lvl_cnt <= lvl_cnt + 22'h000001;
        end
        default:
        begin
          lvl_state <= `LVL_IDLE;
          lvl_cnt   <= 22'h000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain selection per mode
  reg  [6:0] next_gain;
  reg        next_mute;
  wire [5:0] serial_code_clamped;

  // Codes above the top step saturate; the all-ones code means mute
  assign serial_code_clamped = (serial_gain_code > `SERIAL_GAIN_TOP) ?
                               `SERIAL_GAIN_TOP : serial_gain_code;

  always @*
  begin
    next_gain = `LEVEL_PRESET_GAIN;
    next_mute = 1'b0;
    if (in_gain)
    begin
      case ({c4_s, c3_s})
        2'h0:    next_gain = `GAIN_SEL_00;
        2'h1:    next_gain = `GAIN_SEL_01;
        2'h2:    next_gain = `GAIN_SEL_10;
        default: next_gain = `GAIN_SEL_11;
      endcase
    end
    else if (in_serial)
    begin
      next_gain = `SERIAL_GAIN_BASE + {1'b0, serial_code_clamped};
      next_mute = (serial_gain_code == `SERIAL_MUTE_CODE);
    end
    else if (in_level)
      next_gain = lvl_gain;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered control outputs and shared ball routing
  reg left_en;
  reg right_en;

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      op_mode              <= `MODE_LEVEL_CTRL;
      serial_if_enable     <= 1'b0;
      bus_clk_in           <= 1'b1;
      bus_data_in          <= 1'b1;
      ball_c4_out          <= 1'b0;
      ball_c4_oe           <= 1'b0;
      gain_half_db         <= `LEVEL_PRESET_GAIN;
      mute                 <= 1'b0;
      auto_level_control   <= 1'b0;
      emission_limit_on    <= 1'b0;
      limiter_threshold_in <= 1'b0;
      alc_state            <= `LVL_IDLE;
      left_en              <= 1'b0;
      right_en             <= 1'b0;
    end
    else
    begin
      op_mode          <= mode;
      // Bus disabled outside serial mode; idle level high there
      serial_if_enable <= in_serial;
      bus_clk_in       <= in_serial ? c3_s : 1'b1;
      bus_data_in      <= in_serial ? c4_s : 1'b1;
      // Open drain: only ever pulls low
      ball_c4_out      <= 1'b0;
      ball_c4_oe       <= in_serial & serial_sda_drive_low;
      gain_half_db     <= next_gain;
      mute             <= next_mute;
      auto_level_control <= in_level;
      if (in_level)
        emission_limit_on <= c3_s;
      else if (in_serial)
        emission_limit_on <= serial_emission_limit;
      else
        emission_limit_on <= 1'b0;
      // Routes the ball to the analog threshold divider, 45 to 90 % rail
      limiter_threshold_in <= in_level;
      alc_state            <= lvl_state;
      left_en  <= dev_enabled && mode_valid && !next_mute &&
                  !(in_serial && serial_left_shutdown);
      right_en <= dev_enabled && mode_valid && !next_mute &&
                  !(in_serial && serial_right_shutdown);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stages, one per channel
  three_level_modulator #(
    .SAMPLE_W    (SAMPLE_W)
  ) u_mod_left (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .enable      (left_en),
    .sample      (audio_left),
    .out_pos_leg (out_pos_leg_left),
    .out_neg_leg (out_neg_leg_left)
  );

  three_level_modulator #(
    .SAMPLE_W    (SAMPLE_W)
  ) u_mod_right (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .enable      (right_en),
    .sample      (audio_right),
    .out_pos_leg (out_pos_leg_right),
    .out_neg_leg (out_neg_leg_right)
  );

endmodule // amp_mode_gain_control

// ===== bench/pin_strap.sv
// Board strap model for the mode pin and the two shared balls.
// Assumes the bench picks strap levels; ball C4 has a pull-up.
`timescale 1ns/1ps

module pin_strap (
  input  wire       core_clk,
  input  wire [1:0] strap_mode,
  input  wire       strap_c3,
  input  wire       strap_c4,
  input  wire       ball_c4_oe,
  output reg        mode_pin_low,
  output reg        mode_pin_high,
  output reg        ball_c3_in,
  output wire       ball_c4_in
);
  // Strap code 0 ground, 1 supply, 2 open (neither sense high)
  always @(posedge core_clk)
  begin
    mode_pin_low  <= (strap_mode == 2'h0);
    mode_pin_high <= (strap_mode == 2'h1);
    ball_c3_in    <= strap_c3;
  end
  // Open drain: pull-up wins unless the device pulls low
  assign ball_c4_in = strap_c4 & ~ball_c4_oe;
endmodule // pin_strap

// ===== bench/amp_mode_gain_control_assertions.sv
// Checker for mode decode, fixed gains and level controller pacing.
// Assumes it is bound to the top block and sees its ports only.
`timescale 1ns/1ps
`include "amp_mode_regs.vh"

module amp_mode_gain_control_assertions #(
  parameter [21:0] ATTACK_CYC  = 22'h2,
  parameter [21:0] HOLD_CYC    = 22'h4,
  parameter [21:0] RELEASE_CYC = 22'h2
) (
  input wire       core_clk,
  input wire       sys_rst,
  input wire       shutdown_n,
  input wire       ball_c3_in,
  input wire       ball_c4_in,
  input wire       ball_c4_out,
  input wire       ball_c4_oe,
  input wire [1:0] op_mode,
  input wire       serial_if_enable,
  input wire       bus_clk_in,
  input wire [6:0] gain_half_db,
  input wire       mute,
  input wire       auto_level_control,
  input wire       emission_limit_on,
  input wire [1:0] alc_state,
  input wire       out_pos_leg_left,
  input wire       out_neg_leg_left,
  input wire       out_pos_leg_right,
  input wire       out_neg_leg_right
);
  reg  [6:0]  prev_gain;
  reg  [21:0] since;
  reg         last_dec;
  reg  [21:0] hold_run;
  wire        step_dn = (gain_half_db == prev_gain - 7'h01);
  wire        step_up = (gain_half_db == prev_gain + 7'h01);
  wire        lvl     = (op_mode == `MODE_LEVEL_CTRL);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////
  // Spacing of gain changes; only single 0.5 dB steps set direction
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prev_gain <= 7'h24;
      since     <= 22'h0;
      last_dec  <= 1'b0;
      hold_run  <= 22'h0;
    end
    else
    begin
      prev_gain <= gain_half_db;
      // Cycles spent in hold, so a short hold shows even at the floor
      hold_run  <= (alc_state == `LVL_HOLD) ? hold_run + 22'h1 : 22'h0;
      since     <= (gain_half_db != prev_gain) ? 22'h0 : since + 22'h1;
      if (step_dn || step_up)
        last_dec <= step_dn;
    end
  end

  ////////////////////////////////////////////////////////////////////
  a_legs_exclusive: assert property (!(out_pos_leg_left && out_neg_leg_left)
    && !(out_pos_leg_right && out_neg_leg_right)) else $error("both legs high");
  a_serial_enable: assert property ((shutdown_n && $stable(op_mode)) [*8]
    |-> serial_if_enable == (op_mode == `MODE_SERIAL)) else $error("bus enable wrong");
  a_gain_quiet: assert property ((shutdown_n && op_mode == `MODE_GAIN_SEL) [*8]
    |-> !auto_level_control && !emission_limit_on) else $error("gain mode not quiet");
  a_level_active: assert property ((shutdown_n && lvl && $stable(ball_c3_in)) [*8]
    |-> auto_level_control && emission_limit_on == ball_c3_in) else $error("level mode off");
  a_gain_table: assert property ((shutdown_n && op_mode == `MODE_GAIN_SEL
    && $stable({ball_c4_in, ball_c3_in})) [*8]
    |-> gain_half_db == 7'h0C + 7'h0C * {ball_c4_in, ball_c3_in}) else $error("gain table");
  a_bus_follow: assert property ((shutdown_n && op_mode == `MODE_SERIAL
    && $stable(ball_c3_in)) [*8] |-> bus_clk_in == ball_c3_in) else $error("bus clock");
  a_drain_only: assert property (ball_c4_oe |-> !ball_c4_out
    && op_mode == `MODE_SERIAL) else $error("drive outside serial");
  a_gain_range: assert property (!mute |-> gain_half_db >= `LEVEL_MIN_GAIN
    && gain_half_db <= 7'h30) else $error("gain out of range");
  a_attack_pace: assert property (lvl && step_dn && last_dec
    |-> since == ATTACK_CYC - 22'h1) else $error("attack pace");
  a_release_pace: assert property (lvl && step_up && !last_dec
    |-> since == RELEASE_CYC - 22'h1) else $error("release pace");
  a_hold_gap: assert property (lvl && step_up && last_dec
    |-> since >= HOLD_CYC) else $error("hold too short");
  a_hold_length: assert property ($past(alc_state) == `LVL_HOLD
    && alc_state == `LVL_RELEASE |-> hold_run == HOLD_CYC) else $error("hold length");

  c_attack: cover property (lvl && step_dn && last_dec);
  c_release: cover property (lvl && step_up && !last_dec);
  c_top_gain: cover property (op_mode == `MODE_GAIN_SEL && gain_half_db == 7'h30);
  c_drain: cover property (ball_c4_oe);
endmodule // amp_mode_gain_control_assertions

bind amp_mode_gain_control amp_mode_gain_control_assertions #(
  .ATTACK_CYC(ATTACK_CYC), .HOLD_CYC(HOLD_CYC), .RELEASE_CYC(RELEASE_CYC)
) chk (.core_clk, .sys_rst, .shutdown_n, .ball_c3_in, .ball_c4_in, .ball_c4_out,
  .ball_c4_oe, .op_mode, .serial_if_enable, .bus_clk_in, .gain_half_db, .mute,
  .auto_level_control, .emission_limit_on, .alc_state, .out_pos_leg_left, .out_neg_leg_left,
  .out_pos_leg_right, .out_neg_leg_right);

// ===== bench/amp_mode_gain_control_test.sv
// Self-checking bench: strap modes, fixed gains, serial gains, level control.
// Assumes short controller counts (8, 40, 16) set at the instance.
`timescale 1ns/1ps
`include "amp_mode_regs.vh"

`define CHECK(nm, exp, got) \
  begin check_count = check_count + 1; if ((got) !== (exp)) begin \
  num_errors = num_errors + 1; $display("BAD %s exp %0h got %0h", nm, exp, got); end end

module amp_mode_gain_control_test;
  reg         core_clk, sys_rst, shutdown_n, strap_c3, strap_c4, over_threshold;
  reg  [1:0]  strap_mode;
  reg         serial_sda_drive_low, serial_left_shutdown;
  reg         serial_right_shutdown, serial_emission_limit;
  reg  [5:0]  serial_gain_code;
  reg  [15:0] audio_left, audio_right;
  wire        mode_pin_low, mode_pin_high, ball_c3_in, ball_c4_in, ball_c4_oe;
  wire        serial_if_enable, bus_clk_in, bus_data_in, mute, auto_level_control;
  wire        emission_limit_on, limiter_threshold_in;
  wire [1:0]  op_mode, alc_state;
  wire [6:0]  gain_half_db;
  wire        out_pos_leg_left, out_neg_leg_left, out_pos_leg_right, out_neg_leg_right;
  integer     num_errors, check_count, i, lp, ln, rt, cyc;

  pin_strap strap (.core_clk, .strap_mode, .strap_c3, .strap_c4, .ball_c4_oe,
    .mode_pin_low, .mode_pin_high, .ball_c3_in, .ball_c4_in);

  amp_mode_gain_control #(.ATTACK_CYC(22'h8), .HOLD_CYC(22'h28), .RELEASE_CYC(22'h10))
  DUT (.core_clk, .sys_rst, .shutdown_n, .mode_pin_low, .mode_pin_high, .ball_c3_in,
    .ball_c4_in, .ball_c4_out(), .ball_c4_oe, .over_threshold, .serial_sda_drive_low,
    .serial_gain_code, .serial_emission_limit, .serial_left_shutdown,
    .serial_right_shutdown, .audio_left, .audio_right, .op_mode, .serial_if_enable,
    .bus_clk_in, .bus_data_in, .gain_half_db, .mute, .auto_level_control,
    .emission_limit_on, .limiter_threshold_in, .alc_state, .out_pos_leg_left,
    .out_neg_leg_left, .out_pos_leg_right, .out_neg_leg_right);

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask

  // Waits, then lands on a falling edge where outputs are settled
  task settle(input integer n);
  begin
    tick(n);
    @(negedge core_clk);
  end
  endtask

  // Pins only re-latch while shut down
  task set_mode(input [1:0] m);
  begin
    tick(1);
    shutdown_n <= 1'b0;
    strap_mode <= m;
    tick(12);
    shutdown_n <= 1'b1;
    settle(12);
    `CHECK("op_mode", m, op_mode)
  end
  endtask

  task count(input integer n);
  begin
    lp = 0;
    ln = 0;
    rt = 0;
    repeat (n)
    begin
      @(negedge core_clk);
      lp = lp + out_pos_leg_left;
      ln = ln + out_neg_leg_left;
      rt = rt + (out_pos_leg_right | out_neg_leg_right);
    end
  end
  endtask

  // Bounded wait for the next gain change, cycles in cyc
  task wait_step;
    reg [6:0] g;
  begin
    g = gain_half_db;
    cyc = 0;
    while (gain_half_db === g && cyc < 2000)
    begin
      @(negedge core_clk);
      cyc = cyc + 1;
    end
  end
  endtask

  task print_verdict;
  begin
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////////
  // Watchdog, about twenty-five times the expected run
  initial
  begin
    #2000000;
    num_errors = num_errors + 1;
    $display("BAD watchdog exp done got hang");
    print_verdict;
  end

  initial
  begin
    num_errors = 0;
    check_count = 0;
    core_clk = 1'b0;
    sys_rst = 1'b1;
    shutdown_n = 1'b1;
    strap_mode = 2'h1;
    strap_c3 = 1'b0;
    strap_c4 = 1'b0;
    over_threshold = 1'b0;
    serial_sda_drive_low = 1'b0;
    serial_left_shutdown = 1'b0;
    serial_right_shutdown = 1'b0;
    serial_emission_limit = 1'b0;
    serial_gain_code = 6'h00;
    audio_left = 16'h0000;
    audio_right = 16'h0000;
    tick(4);
    sys_rst <= 1'b0;
    settle(15);
    // Gain select: every strap pair, then features stay off
    for (i = 0; i < 4; i = i + 1)
    begin
      tick(1);
      strap_c3 <= i[0];
      strap_c4 <= i[1];
      settle(10);
      `CHECK("gain_sel", 7'h0C * (i + 1), gain_half_db)
    end
    `CHECK("gm_bus", 1'b0, serial_if_enable)
    `CHECK("gm_alc", 1'b0, auto_level_control)
    `CHECK("gm_emis", 1'b0, emission_limit_on)
    tick(1);
    strap_mode <= 2'h2;
    audio_left <= 16'h0400;
    audio_right <= 16'h4000;
    settle(10);
    `CHECK("mode_held", 2'h1, op_mode)
    count(256);
    `CHECK("density", 1'b1, rt > lp && lp > 0)
    tick(1);
    audio_left <= 16'hC000;
    settle(6);
    count(64);
    `CHECK("neg_only", 1'b1, lp == 0 && ln > 0)
    tick(1);
    shutdown_n <= 1'b0;
    settle(10);
    count(64);
    `CHECK("sd_quiet", 0, ln + rt)
    // Serial mode: bus pins, open drain, gain codes, channel off
    set_mode(2'h0);
    for (i = 0; i < 2; i = i + 1)
    begin
      tick(1);
      strap_c3 <= i[0];
      settle(10);
      `CHECK("bus_clk", i[0], bus_clk_in)
    end
    tick(1);
    serial_sda_drive_low <= 1'b1;
    settle(10);
    `CHECK("drain", 2'h2, {ball_c4_oe, bus_data_in})
    tick(1);
    serial_sda_drive_low <= 1'b0;
    settle(10);
    `CHECK("bus_data", 1'b1, bus_data_in)
    for (i = 0; i < 5; i = i + 1)
    begin
      tick(1);
      serial_gain_code <= (i == 4) ? 6'h3F : i * 20;
      settle(4);
      if (i == 4)
        `CHECK("mute", 1'b1, mute)
      else
        `CHECK("s_gain", (i == 3) ? 48 : i * 20 + 2, gain_half_db)
    end
    tick(1);
    serial_gain_code <= 6'h0A;
    audio_left <= 16'h4000;
    serial_left_shutdown <= 1'b1;
    settle(8);
    count(64);
    `CHECK("lr_off", 1'b1, lp + ln == 0 && rt > 0)
    tick(1);
    serial_left_shutdown <= 1'b0;
    serial_right_shutdown <= 1'b1;
    serial_emission_limit <= 1'b1;
    settle(8);
    count(64);
    `CHECK("rl_off", 1'b1, lp > 0 && rt == 0)
    `CHECK("s_emis", 1'b1, emission_limit_on)
    // Level mode: routing, preset, attack, floor, hold, release
    set_mode(2'h2);
    `CHECK("alc_on", 1'b1, auto_level_control)
    `CHECK("thr_route", 2'h1, {serial_if_enable, limiter_threshold_in})
    `CHECK("preset", 7'h24, gain_half_db)
    `CHECK("emis_on", 1'b1, emission_limit_on)
    tick(1);
    strap_c3 <= 1'b0;
    settle(10);
    `CHECK("emis_off", 1'b0, emission_limit_on)
    tick(1);
    over_threshold <= 1'b1;
    wait_step;
    `CHECK("attack1", 7'h23, gain_half_db)
    wait_step;
    `CHECK("attack_gap", 8, cyc)
    settle(400);
    `CHECK("floor", 7'h02, gain_half_db)
    tick(1);
    over_threshold <= 1'b0;
    wait_step;
    `CHECK("hold", 1'b1, cyc >= 40)
    wait_step;
    `CHECK("rel_gap", 16, cyc)
    settle(700);
    `CHECK("back", {`LVL_IDLE, 7'h24}, {alc_state, gain_half_db})
    print_verdict;
  end
endmodule // amp_mode_gain_control_test
